/* core/mad_pkg.sv */
// Constants and types shared by the multiply/ALU datapath files.
// Assumes a single 100 MHz clock and 16-bit on-chip data memories.
package mad_pkg;
   // Data widths and field positions
   localparam int ACC_W   = 36;
   localparam int HALF_W  = 16;
   localparam int Y_W     = 32;
   localparam int P_W     = 32;
   localparam int HI_LSB  = 16;
   localparam int SIGN32  = 31;
   localparam int SIGN36  = 35;
   localparam int GUARD_W = 4;
   // Low-half clear field bits and reset values
   localparam int CLR_Y_BIT   = 0;
   localparam int CLR_ACC_BIT = 1;
   localparam logic [35:0] ACC_RST = 36'h000000000;
   localparam logic [31:0] Y_RST   = 32'h00000000;
   localparam logic [15:0] X_RST   = 16'h0000;
   // Saturation limits of a stored half
   localparam logic [15:0] SAT_HI_POS = 16'h7fff;
   localparam logic [15:0] SAT_HI_NEG = 16'h8000;
   localparam logic [15:0] SAT_LO_POS = 16'hffff;
   localparam logic [15:0] SAT_LO_NEG = 16'h0000;
   // Product alignment codes
   localparam logic [1:0] ALIGN_X1    = 2'h0;
   localparam logic [1:0] ALIGN_X4    = 2'h1;
   localparam logic [1:0] ALIGN_DIV4  = 2'h2;
   // Instruction duration in cycles
   localparam int CYC_ONE = 1;
   localparam int CYC_TWO = 2;

   typedef enum logic [3:0] {
      F_NONE = 4'h0, F_MUL  = 4'h1, F_LDPM = 4'h2, F_ADDPM = 4'h3,
      F_SUBPM = 4'h4, F_LDP = 4'h5, F_ADDP = 4'h6, F_SUBP  = 4'h7,
      F_LDY  = 4'h8, F_ADDY = 4'h9, F_SUBY = 4'ha, F_AND   = 4'hb,
      F_OR   = 4'hc, F_XOR  = 4'hd, F_TSUB = 4'he, F_TAND  = 4'hf
   } mad_func_t;

   typedef enum logic [3:0] {
      T_NONE  = 4'h0, T_Y    = 4'h1, T_YA    = 4'h2, T_YL    = 4'h3,
      T_AT    = 4'h4, T_ATL  = 4'h5, T_XY    = 4'h6, T_PTR   = 4'h7,
      T_ST_Y  = 4'h8, T_ST_YL = 4'h9, T_ST_A = 4'ha, T_ST_AL = 4'hb,
      T_XCH_Y = 4'hc, T_XCH_YL = 4'hd, T_XCH_A = 4'he, T_XCH_AL = 4'hf
   } mad_trans_t;

   // Post-modify select, also the compound exchange mode
   typedef enum logic [1:0] {
      EXCHANGE_MODE_ZERO_PLUS      = 2'h0,
      EXCHANGE_MODE_PLUS_ZERO      = 2'h1,
      EXCHANGE_MODE_MINUS_TWO      = 2'h2,
      EXCHANGE_MODE_INCREMENT_PAIR = 2'h3
   } mad_mod_t;

   typedef enum logic [1:0] {
      S_IDLE = 2'h0,
      S_PH1  = 2'h1,
      S_PH2  = 2'h2
   } mad_state_t;
endpackage

/* core/mad_sat_limit.sv */
// Overflow limiting of an accumulator half on its way to memory.
// Assumes a 36-bit accumulator; purely combinational.
`timescale 1ns/100ps
module mad_sat_limit (
   input  wire logic [35:0] acc_i,
   input  wire logic        en_i,
   output logic      [15:0] hi_o,
   output logic      [15:0] lo_o
);
   logic ovf;

   // Overflow when bits 35..31 disagree, value not representable in 32
   assign ovf = !(&acc_i[35:31]) && (|acc_i[35:31]);

   // Clamp toward the sign of the full value
   always_comb begin
      hi_o = acc_i[31:16];
      lo_o = acc_i[15:0];
      if (en_i && ovf) begin
         hi_o = acc_i[35] ? mad_pkg::SAT_HI_NEG : mad_pkg::SAT_HI_POS;
         lo_o = acc_i[35] ? mad_pkg::SAT_LO_NEG : mad_pkg::SAT_LO_POS;
      end
   end
endmodule

/* core/mad_ptr_step.sv */
// Pointer post-modification adder with a signed step.
// Assumes pointers wrap at their own width.
`timescale 1ns/100ps
module mad_ptr_step #(
   parameter int AW = 16
) (
   input  wire logic [AW-1:0] base_i,
   input  wire logic [AW-1:0] step_i,
   output logic      [AW-1:0] next_o
);
   // Wrap-around is intended: a step of all ones subtracts one
   assign next_o = AW'(base_i + step_i);
endmodule

/* core/mad_datapath.sv */
// Multiply/ALU instruction datapath: product, accumulators, x/y operand
// registers, RAM and ROM pointers. Driven by a sequencer that presents one
// instruction at a time; RAM and ROM answer reads in the same cycle.
// What this block does
// - any function pairs with any transfer
// - cycle count set by transfer kind, and by IN_CACHE_I for dual loads
// - signed x times y high into product
// - product and y sign-extended to 36 bits
// - product alignment follows align field
// - load old product while multiplying anew
// - add or subtract product, with multiply
// - y load, add, sub, and, or, xor
// - test functions change only the flags
// - y high load, low cleared if enabled
// - y low load keeps high half
// - accumulator high load sign-fills guard bits
// - accumulator low load keeps upper bits
// - pointer-only transfer; x loads from RAM
// - store y high or low to RAM
// - accumulator store limited when saturation enabled
// - y exchange writes old half back
// - accumulator high exchange, sign-fill, limited writeback
// - accumulator low exchange writes old high half
// - ROM pointer post-increments by one or i
// - RAM pointer post-modifies 0, +1, -1, j
// - compound addressing uses two post-modifications
// - functions other than multiply set flags, transfers do not
// - load, multiply, accumulate in one instruction
`timescale 1ns/100ps
module mad_datapath #(
   parameter int AW = 16
) (
   input  wire logic          CLK_I,
   input  wire logic          NRST_I,
   input  wire logic          START_I,
   input  wire logic [3:0]    FUNC_I,
   input  wire logic [3:0]    TRANS_I,
   input  wire logic          SRC_I,
   input  wire logic          DST_I,
   input  wire logic          TGT_I,
   input  wire logic          XLOAD_I,
   input  wire logic          ROM_MOD_I,
   input  wire logic [1:0]    RAM_SEL_I,
   input  wire logic [1:0]    RAM_MOD_I,
   input  wire logic          IN_CACHE_I,
   input  wire logic [1:0]    LOW_HALF_ZERO_SEL_I,
   input  wire logic          OVERFLOW_LIMIT_SEL_I,
   input  wire logic [1:0]    ALIGN_I,
   input  wire logic [AW-1:0] ROM_INC_I,
   input  wire logic [AW-1:0] RAM_INC_J_I,
   input  wire logic [AW-1:0] RAM_INC_K_I,
   input  wire logic          PTR_WR_I,
   input  wire logic [2:0]    PTR_WR_SEL_I,
   input  wire logic [AW-1:0] PTR_WR_DATA_I,
   input  wire logic [15:0]   RAM_RDATA_I,
   input  wire logic [15:0]   ROM_RDATA_I,
   output logic               BUSY_O,
   output logic               DONE_O,
   output logic      [AW-1:0] RAM_ADDR_O,
   output logic               RAM_RD_O,
   output logic               RAM_WR_O,
   output logic      [15:0]   RAM_WDATA_O,
   output logic      [AW-1:0] ROM_ADDR_O,
   output logic               ROM_RD_O,
   output logic      [35:0]   ACC0_O,
   output logic      [35:0]   ACC1_O,
   output logic      [31:0]   Y_O,
   output logic      [15:0]   X_O,
   output logic      [31:0]   P_O,
   output logic               NEGATIVE_FLAG_O,
   output logic               ZERO_FLAG_O,
   output logic               WIDE_OVERFLOW_FLAG_O,
   output logic               NARROW_OVERFLOW_FLAG_O,
   output logic      [AW-1:0] ROM_POINTER_O
);
   if (AW < 2) begin : g_bad
      $error("mad_datapath: AW must be at least 2");
   end

   // All checks below run on the one clock and pause during reset
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);

   mad_pkg::mad_state_t state;
   mad_pkg::mad_func_t  f_q;
   mad_pkg::mad_trans_t t_q, t_in;
   mad_pkg::mad_mod_t   rmod_q;
   logic          src_q, dst_q, tgt_q, xl_q, rom_mod_q, two_q;
   logic [1:0]    rsel_q;
   logic [35:0]   acc [2];
   logic [35:0]   next_acc [2];
   logic [AW-1:0] ram_pointer_set [4];
   logic          accept, commit, finish;
   logic          rd_ram, wr_plain, rd_rom, is_xch, uses_ram, two_in;
   logic [15:0]   sat_hi, sat_lo, wval;
   logic [AW-1:0] ram_step, ram_next, rom_step, rom_next;

   assign t_in   = mad_pkg::mad_trans_t'(TRANS_I);
   assign accept = START_I && !BUSY_O;
   assign commit = (state == mad_pkg::S_PH1);
   assign finish = (commit && !two_q) || (state == mad_pkg::S_PH2);
   assign ACC0_O = acc[0];
   assign ACC1_O = acc[1];
   assign ROM_POINTER_O = ROM_ADDR_O;

   // Decode of the transfer being offered, used at the accept edge
   always_comb begin
      rd_ram   = t_in inside {mad_pkg::T_Y, mad_pkg::T_YL, mad_pkg::T_AT,
                  mad_pkg::T_ATL, mad_pkg::T_XY, mad_pkg::T_XCH_Y,
                  mad_pkg::T_XCH_YL, mad_pkg::T_XCH_A, mad_pkg::T_XCH_AL};
      wr_plain = t_in inside {mad_pkg::T_ST_Y, mad_pkg::T_ST_YL,
                  mad_pkg::T_ST_A, mad_pkg::T_ST_AL};
      rd_rom   = XLOAD_I && (t_in inside {mad_pkg::T_Y, mad_pkg::T_YA,
                  mad_pkg::T_XCH_Y});
      // Writes and exchanges 2/2, dual ROM+RAM loads 2/1
      two_in   = wr_plain || TRANS_I[3] ||
                 (XLOAD_I && !IN_CACHE_I &&
                  (t_in inside {mad_pkg::T_Y, mad_pkg::T_YA}));
   end

   assign is_xch   = (t_q inside {mad_pkg::T_XCH_Y, mad_pkg::T_XCH_YL,
                      mad_pkg::T_XCH_A, mad_pkg::T_XCH_AL});
   assign uses_ram = !(t_q inside {mad_pkg::T_NONE, mad_pkg::T_YA});

   // Store value limited on overflow when enabled
   mad_sat_limit u_sat (
      .acc_i (acc[TGT_I]),
      .en_i  (OVERFLOW_LIMIT_SEL_I),
      .hi_o  (sat_hi),
      .lo_o  (sat_lo)
   );

   // Old contents captured at accept, so writes see pre-instruction state
   always_comb begin
      case (t_in)
         mad_pkg::T_ST_Y, mad_pkg::T_XCH_Y:   wval = Y_O[31:16];
         mad_pkg::T_ST_YL, mad_pkg::T_XCH_YL: wval = Y_O[15:0];
         mad_pkg::T_ST_AL:                    wval = sat_lo;
         default:                             wval = sat_hi;
      endcase
   end

   // Sequencer: phase one reads and commits, phase two finishes
   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         state <= mad_pkg::S_IDLE;
      end else begin
         case (state)
            mad_pkg::S_IDLE: if (accept) state <= mad_pkg::S_PH1;
            mad_pkg::S_PH1:  state <= two_q ? mad_pkg::S_PH2
                                            : mad_pkg::S_IDLE;
            mad_pkg::S_PH2:  state <= mad_pkg::S_IDLE;
            default:         state <= mad_pkg::S_IDLE;
         endcase
      end
   end

   // Busy and done flags; done is a one-cycle pulse
   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         BUSY_O <= 1'b0;
         DONE_O <= 1'b0;
      end else begin
         BUSY_O <= accept || (commit && two_q);
         DONE_O <= finish;
      end
   end

   // Instruction capture: both parts chosen independently
   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         f_q       <= mad_pkg::F_NONE;
         t_q       <= mad_pkg::T_NONE;
         rmod_q    <= mad_pkg::EXCHANGE_MODE_ZERO_PLUS;
         {src_q, dst_q, tgt_q, xl_q, rom_mod_q, two_q} <= 6'h00;
         rsel_q    <= 2'h0;
      end else if (accept) begin
         f_q       <= mad_pkg::mad_func_t'(FUNC_I);
         t_q       <= t_in;
         rmod_q    <= mad_pkg::mad_mod_t'(RAM_MOD_I);
         {src_q, dst_q, tgt_q} <= {SRC_I, DST_I, TGT_I};
         xl_q      <= rd_rom;
         rom_mod_q <= ROM_MOD_I;
         two_q     <= two_in;
         rsel_q    <= RAM_SEL_I;
      end
   end

   // Pointer steps: first and second post-modification
   always_comb begin
      ram_step = '0;
      if (state == mad_pkg::S_PH2) begin
         case (rmod_q)
            mad_pkg::EXCHANGE_MODE_ZERO_PLUS: ram_step = AW'(1);
            mad_pkg::EXCHANGE_MODE_MINUS_TWO: ram_step = AW'(2);
            mad_pkg::EXCHANGE_MODE_INCREMENT_PAIR: ram_step = RAM_INC_K_I;
            default: ram_step = '0;
         endcase
      end else begin
         case (rmod_q)
            mad_pkg::EXCHANGE_MODE_PLUS_ZERO: ram_step = AW'(1);
            mad_pkg::EXCHANGE_MODE_MINUS_TWO: ram_step = '1;
            mad_pkg::EXCHANGE_MODE_INCREMENT_PAIR: ram_step = RAM_INC_J_I;
            default: ram_step = '0;
         endcase
      end
      rom_step = rom_mod_q ? ROM_INC_I : AW'(1);
   end

   mad_ptr_step #(.AW(AW)) u_ram_step (
      .base_i (ram_pointer_set[rsel_q]),
      .step_i (ram_step),
      .next_o (ram_next)
   );

   mad_ptr_step #(.AW(AW)) u_rom_step (
      .base_i (ROM_ADDR_O),
      .step_i (rom_step),
      .next_o (rom_next)
   );

   // RAM pointers; loads from the sequencer only while idle
   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         for (int i = 0; i < 4; i++) ram_pointer_set[i] <= '0;
      end else if ((commit && uses_ram) ||
                   (state == mad_pkg::S_PH2 && is_xch)) begin
         ram_pointer_set[rsel_q] <= ram_next;
      end else if (state == mad_pkg::S_IDLE && PTR_WR_I &&
                   !PTR_WR_SEL_I[2]) begin
         ram_pointer_set[PTR_WR_SEL_I[1:0]] <= PTR_WR_DATA_I;
      end
   end

   // ROM port; the address register is the ROM pointer itself
   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         ROM_ADDR_O <= '0;
         ROM_RD_O   <= 1'b0;
      end else begin
         ROM_RD_O <= accept && rd_rom;
         if (commit && xl_q) begin
            ROM_ADDR_O <= rom_next;
         end else if (state == mad_pkg::S_IDLE && PTR_WR_I &&
                      PTR_WR_SEL_I[2]) begin
            ROM_ADDR_O <= PTR_WR_DATA_I;
         end
      end
   end

   // RAM port: read or store in phase one, exchange write in phase two
   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         RAM_ADDR_O  <= '0;
         RAM_RD_O    <= 1'b0;
         RAM_WR_O    <= 1'b0;
         RAM_WDATA_O <= 16'h0000;
      end else if (accept) begin
         RAM_ADDR_O  <= ram_pointer_set[RAM_SEL_I];
         RAM_RD_O    <= rd_ram;
         RAM_WR_O    <= wr_plain;
         RAM_WDATA_O <= wval;
      end else if (commit) begin
         RAM_ADDR_O  <= ram_next;
         RAM_RD_O    <= 1'b0;
         RAM_WR_O    <= is_xch;
      end else begin
         RAM_RD_O    <= 1'b0;
         RAM_WR_O    <= 1'b0;
      end
   end

   // Function part
   logic [35:0] p_ext, p_al, y_ext, opnd, asrc, res;
   logic [36:0] sum;
   logic        wr_acc, set_flags, use_p, is_sub, is_arith;

   always_comb begin
      p_ext = {{mad_pkg::GUARD_W{P_O[mad_pkg::SIGN32]}}, P_O};
      y_ext = {{mad_pkg::GUARD_W{Y_O[mad_pkg::SIGN32]}}, Y_O};
      case (ALIGN_I)
         mad_pkg::ALIGN_X4:   p_al = {p_ext[33:0], 2'h0};
         mad_pkg::ALIGN_DIV4: p_al = {{2{p_ext[35]}}, p_ext[35:2]};
         default:             p_al = p_ext;
      endcase
      use_p  = f_q inside {mad_pkg::F_LDPM, mad_pkg::F_ADDPM,
                mad_pkg::F_SUBPM, mad_pkg::F_LDP, mad_pkg::F_ADDP,
                mad_pkg::F_SUBP};
      is_sub = f_q inside {mad_pkg::F_SUBPM, mad_pkg::F_SUBP,
                mad_pkg::F_SUBY, mad_pkg::F_TSUB};
      opnd   = use_p ? p_al : y_ext;
      asrc   = acc[src_q];
      sum    = is_sub ? ({asrc[35], asrc} - {opnd[35], opnd})
                      : ({asrc[35], asrc} + {opnd[35], opnd});
      is_arith = 1'b0;
      case (f_q)
         mad_pkg::F_LDPM, mad_pkg::F_LDP, mad_pkg::F_LDY: res = opnd;
         mad_pkg::F_ADDPM, mad_pkg::F_SUBPM, mad_pkg::F_ADDP,
         mad_pkg::F_SUBP, mad_pkg::F_ADDY, mad_pkg::F_SUBY,
         mad_pkg::F_TSUB: begin
            res      = sum[35:0];
            is_arith = 1'b1;
         end
         mad_pkg::F_AND, mad_pkg::F_TAND: res = asrc & y_ext;
         mad_pkg::F_OR:                   res = asrc | y_ext;
         mad_pkg::F_XOR:                  res = asrc ^ y_ext;
         default:                         res = asrc;
      endcase
      set_flags = !(f_q inside {mad_pkg::F_NONE, mad_pkg::F_MUL});
      wr_acc    = set_flags &&
                  !(f_q inside {mad_pkg::F_TSUB, mad_pkg::F_TAND});
   end

   // Product register; the old product feeds the ALU in the same edge
   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         P_O <= 32'h00000000;
      end else if (commit && (f_q inside {mad_pkg::F_MUL, mad_pkg::F_LDPM,
                   mad_pkg::F_ADDPM, mad_pkg::F_SUBPM})) begin
         P_O <= $signed({{16{X_O[15]}}, X_O}) *
                $signed({{16{Y_O[31]}}, Y_O[31:16]});
      end
   end

   // Flags from function results only
   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         {NEGATIVE_FLAG_O, ZERO_FLAG_O} <= 2'h0;
         {WIDE_OVERFLOW_FLAG_O, NARROW_OVERFLOW_FLAG_O} <= 2'h0;
      end else if (commit && set_flags) begin
         NEGATIVE_FLAG_O        <= res[mad_pkg::SIGN36];
         ZERO_FLAG_O            <= (res == mad_pkg::ACC_RST);
         WIDE_OVERFLOW_FLAG_O   <= is_arith && (sum[36] != sum[35]);
         NARROW_OVERFLOW_FLAG_O <= !(&res[35:31]) && (|res[35:31]);
      end
   end

   // Accumulators: function result first, a transfer load overrides
   always_comb begin
      next_acc[0] = acc[0];
      next_acc[1] = acc[1];
      if (commit && wr_acc) next_acc[dst_q] = res;
      if (commit) begin
         case (t_q)
            mad_pkg::T_AT, mad_pkg::T_XCH_A: begin
               next_acc[tgt_q][35:16] = {{mad_pkg::GUARD_W{RAM_RDATA_I[15]}},
                                         RAM_RDATA_I};
               if (LOW_HALF_ZERO_SEL_I[mad_pkg::CLR_ACC_BIT])
                  next_acc[tgt_q][15:0] = 16'h0000;
            end
            mad_pkg::T_ATL, mad_pkg::T_XCH_AL:
               next_acc[tgt_q][15:0] = RAM_RDATA_I;
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         acc[0] <= mad_pkg::ACC_RST;
         acc[1] <= mad_pkg::ACC_RST;
      end else begin
         acc[0] <= next_acc[0];
         acc[1] <= next_acc[1];
      end
   end

   // Operand registers y and x
   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         Y_O <= mad_pkg::Y_RST;
         X_O <= mad_pkg::X_RST;
      end else if (commit) begin
         case (t_q)
            mad_pkg::T_Y, mad_pkg::T_YA, mad_pkg::T_XCH_Y: begin
               Y_O[31:16] <= (t_q == mad_pkg::T_YA) ? acc[tgt_q][31:16]
                                                    : RAM_RDATA_I;
               if (LOW_HALF_ZERO_SEL_I[mad_pkg::CLR_Y_BIT])
                  Y_O[15:0] <= 16'h0000;
            end
            mad_pkg::T_YL, mad_pkg::T_XCH_YL:
               Y_O[15:0] <= RAM_RDATA_I;
            default: ;
         endcase
         if (t_q == mad_pkg::T_XY) X_O <= RAM_RDATA_I;
         else if (xl_q) X_O <= ROM_RDATA_I;
      end
   end

   // Checks
   sequence s_accept;
      START_I && !BUSY_O;
   endsequence

   a_single_cycle: assert property (
      s_accept and !two_in |-> ##2 DONE_O)
      else $error("single-cycle instruction not done in one cycle");
   a_double_cycle: assert property (
      s_accept and two_in |-> ##2 !DONE_O ##1 DONE_O)
      else $error("two-cycle instruction timing wrong");
   a_mul_product: assert property (
      commit && f_q == mad_pkg::F_MUL |=> $signed(P_O) ==
      $signed($past(X_O)) * $signed($past(Y_O[31:16])))
      else $error("product does not match operands");
   a_test_keeps: assert property (
      commit && f_q inside {mad_pkg::F_TSUB, mad_pkg::F_TAND} &&
      t_q == mad_pkg::T_PTR |=> $stable(ACC0_O) && $stable(ACC1_O))
      else $error("test function changed an accumulator");
   a_low_keeps: assert property (
      commit && t_q == mad_pkg::T_YL |=> $stable(Y_O[31:16]) &&
      Y_O[15:0] == $past(RAM_RDATA_I))
      else $error("low half load disturbed the high half");
   a_guard_fill: assert property (
      commit && t_q == mad_pkg::T_AT |=>
      acc[$past(tgt_q)][35:31] == {5{$past(RAM_RDATA_I[15])}})
      else $error("guard bits not sign-filled");
   a_flags_hold: assert property (
      commit && f_q == mad_pkg::F_NONE |=> $stable(NEGATIVE_FLAG_O) &&
      $stable(ZERO_FLAG_O) && $stable(NARROW_OVERFLOW_FLAG_O))
      else $error("transfer changed the flags");
   a_xch_write: assert property (
      s_accept and t_in == mad_pkg::T_XCH_YL |-> ##1 RAM_RD_O ##1
      RAM_WR_O && RAM_WDATA_O == $past(Y_O[15:0], 2))
      else $error("exchange did not write the old low half");
   a_ptr_inc: assert property (
      commit && t_q == mad_pkg::T_PTR &&
      rmod_q == mad_pkg::EXCHANGE_MODE_PLUS_ZERO |=>
      ram_pointer_set[$past(rsel_q)] ==
      AW'($past(ram_pointer_set[rsel_q]) + 1'b1))
      else $error("pointer not incremented by one");
endmodule

/* bench/mad_mem_model.sv */
// RAM and ROM model answering reads in the cycle of the strobe.
// Assumes the datapath's registered address, strobe and write data outputs.
`timescale 1ns/100ps
module mad_mem_model #(
   parameter int AW = 16
) (
   input  wire logic          clk_i,
   input  wire logic [AW-1:0] ram_addr_i,
   input  wire logic          ram_rd_i,
   input  wire logic          ram_wr_i,
   input  wire logic [15:0]   ram_wdata_i,
   input  wire logic [AW-1:0] rom_addr_i,
   input  wire logic          rom_rd_i,
   output logic      [15:0]   ram_rdata_o,
   output logic      [15:0]   rom_rdata_o
);
   logic [15:0] ram [16];
   logic [15:0] rom [16];
   logic [15:0] ram_last = 16'h0000;
   logic [15:0] rom_last = 16'h0000;
   // Idle data lines toggle so a stale word cannot pass for a read in the cycle after it
   assign ram_rdata_o = ram_rd_i ? ram[ram_addr_i[3:0]] : ~ram_last;
   assign rom_rdata_o = rom_rd_i ? rom[rom_addr_i[3:0]] : ~rom_last;
   // Small arrays: only the low address bits select a word
   always @(posedge clk_i) begin
      if (ram_wr_i) ram[ram_addr_i[3:0]] <= ram_wdata_i;
      ram_last <= ram_rdata_o;
      rom_last <= rom_rdata_o;
   end
endmodule

/* bench/multiply_alu_datapath_test.sv */
// Self-checking bench for the multiply/ALU datapath.
// Assumes the memory model answers reads combinationally.
`timescale 1ns/100ps
module multiply_alu_datapath_test;
   logic CLK_I = 1'b0, NRST_I = 1'b0, START_I = 1'b0, SRC_I = 1'b0;
   logic DST_I = 1'b0, TGT_I = 1'b0, XLOAD_I = 1'b0, ROM_MOD_I = 1'b0;
   logic IN_CACHE_I = 1'b0, OVERFLOW_LIMIT_SEL_I = 1'b0, PTR_WR_I = 1'b0;
   logic [3:0] FUNC_I = 4'h0, TRANS_I = 4'h0;
   logic [1:0] RAM_SEL_I = 2'h0, RAM_MOD_I = 2'h0, ALIGN_I = 2'h0;
   logic [1:0] LOW_HALF_ZERO_SEL_I = 2'h1;
   logic [2:0] PTR_WR_SEL_I = 3'h0;
   logic [15:0] ROM_INC_I = 16'h0002, RAM_INC_J_I = 16'h0003;
   logic [15:0] RAM_INC_K_I = 16'h0001, PTR_WR_DATA_I = 16'h0000;
   logic [15:0] RAM_RDATA_I, ROM_RDATA_I, RAM_WDATA_O, X_O;
   logic [15:0] RAM_ADDR_O, ROM_ADDR_O, ROM_POINTER_O, r [5];
   logic BUSY_O, DONE_O, RAM_RD_O, RAM_WR_O, ROM_RD_O;
   logic NEGATIVE_FLAG_O, ZERO_FLAG_O, WIDE_OVERFLOW_FLAG_O;
   logic NARROW_OVERFLOW_FLAG_O;
   logic [35:0] ACC0_O, ACC1_O, a1e, res;
   logic [31:0] Y_O, P_O, ye, pe;
   int err_count = 0, samples_checked = 0, seed = 32'hc71103ef;

   mad_datapath u_mad_datapath (.CLK_I(CLK_I), .NRST_I(NRST_I),
      .START_I(START_I), .FUNC_I(FUNC_I), .TRANS_I(TRANS_I), .SRC_I(SRC_I),
      .DST_I(DST_I), .TGT_I(TGT_I), .XLOAD_I(XLOAD_I), .ROM_MOD_I(ROM_MOD_I),
      .RAM_SEL_I(RAM_SEL_I), .RAM_MOD_I(RAM_MOD_I), .IN_CACHE_I(IN_CACHE_I),
      .LOW_HALF_ZERO_SEL_I(LOW_HALF_ZERO_SEL_I), .ALIGN_I(ALIGN_I),
      .OVERFLOW_LIMIT_SEL_I(OVERFLOW_LIMIT_SEL_I), .ROM_INC_I(ROM_INC_I),
      .RAM_INC_J_I(RAM_INC_J_I), .RAM_INC_K_I(RAM_INC_K_I),
      .PTR_WR_I(PTR_WR_I), .PTR_WR_SEL_I(PTR_WR_SEL_I),
      .PTR_WR_DATA_I(PTR_WR_DATA_I), .RAM_RDATA_I(RAM_RDATA_I),
      .ROM_RDATA_I(ROM_RDATA_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O),
      .RAM_ADDR_O(RAM_ADDR_O), .RAM_RD_O(RAM_RD_O), .RAM_WR_O(RAM_WR_O),
      .RAM_WDATA_O(RAM_WDATA_O), .ROM_ADDR_O(ROM_ADDR_O),
      .ROM_RD_O(ROM_RD_O), .ACC0_O(ACC0_O), .ACC1_O(ACC1_O), .Y_O(Y_O),
      .X_O(X_O), .P_O(P_O), .NEGATIVE_FLAG_O(NEGATIVE_FLAG_O),
      .ZERO_FLAG_O(ZERO_FLAG_O), .WIDE_OVERFLOW_FLAG_O(WIDE_OVERFLOW_FLAG_O),
      .NARROW_OVERFLOW_FLAG_O(NARROW_OVERFLOW_FLAG_O),
      .ROM_POINTER_O(ROM_POINTER_O));
   mad_mem_model u_mad_mem_model (.clk_i(CLK_I), .ram_addr_i(RAM_ADDR_O),
      .ram_rd_i(RAM_RD_O), .ram_wr_i(RAM_WR_O), .ram_wdata_i(RAM_WDATA_O),
      .rom_addr_i(ROM_ADDR_O), .rom_rd_i(ROM_RD_O),
      .ram_rdata_o(RAM_RDATA_I), .rom_rdata_o(ROM_RDATA_I));

   // 100 MHz clock
   always #5 CLK_I = ~CLK_I;

   // Sign extension into the accumulator width
   function automatic logic [35:0] sx(input logic [31:0] v);
      return {{4{v[31]}}, v};
   endfunction

   task automatic tally_and_finish;
      if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [35:0] e, g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   // Pointer loads only while idle; the caller drops the strobe at the end
   task automatic load_ptr(input logic [2:0] s, input logic [15:0] d);
      PTR_WR_I = 1'b1;
      PTR_WR_SEL_I = s;
      PTR_WR_DATA_I = d;
      @(posedge CLK_I);
      #1;
   endtask

   // One instruction; counts edges from acceptance to the done pulse
   task automatic run(input logic [3:0] f, t, input int cyc);
      int n;
      FUNC_I = f;
      TRANS_I = t;
      START_I = 1'b1;
      @(posedge CLK_I);
      #1 START_I = 1'b0;
      n = 0;
      while (DONE_O !== 1'b1) begin
         @(posedge CLK_I);
         #1 n++;
         if (n > 20) begin
            err_count++;
            tally_and_finish();
         end
      end
      chk("cycles", 36'(cyc), 36'(n));
      chk("busy", 36'h0, 36'(BUSY_O));
   endtask

   // Random operands per pass, same chain of paired statements
   initial begin
      repeat (16) @(posedge CLK_I);
      #1 NRST_I = 1'b1;
      ye = 32'h0;
      repeat (4) begin
         foreach (r[i]) r[i] = 16'($random(seed));
         u_mad_mem_model.ram[4] = r[0];
         u_mad_mem_model.ram[5] = r[1];
         u_mad_mem_model.rom[8] = r[2];
         u_mad_mem_model.rom[9] = r[3];
         u_mad_mem_model.ram[7] = r[4];
         u_mad_mem_model.ram[8] = r[0];
         load_ptr(3'h0, 16'h0004);
         load_ptr(3'h4, 16'h0008);
         PTR_WR_I = 1'b0;
         XLOAD_I = 1'b0;
         RAM_MOD_I = 2'h1;
         run(mad_pkg::F_NONE, mad_pkg::T_YL, 1);
         ye[15:0] = r[0];
         chk("y_low", 36'(ye), 36'(Y_O));
         XLOAD_I = 1'b1;
         RAM_MOD_I = 2'h0;
         IN_CACHE_I = 1'b0;
         run(mad_pkg::F_NONE, mad_pkg::T_Y, 2);
         ye = {r[1], 16'h0000};
         chk("y_high", 36'(ye), 36'(Y_O));
         chk("x", 36'(r[2]), 36'(X_O));
         chk("rom_ptr", 36'h9, 36'(ROM_POINTER_O));
         IN_CACHE_I = 1'b1;
         RAM_MOD_I = 2'h1;
         run(mad_pkg::F_MUL, mad_pkg::T_Y, 1);
         pe = $signed(r[2]) * $signed(r[1]);
         chk("p_old_ops", 36'(pe), 36'(P_O));
         chk("x_new", 36'(r[3]), 36'(X_O));
         XLOAD_I = 1'b0;
         DST_I = 1'b1;
         run(mad_pkg::F_LDPM, mad_pkg::T_NONE, 1);
         a1e = sx(pe);
         pe = $signed(r[3]) * $signed(r[1]);
         chk("acc1", a1e, ACC1_O);
         chk("p_new", 36'(pe), 36'(P_O));
         RAM_MOD_I = 2'h0;
         run(mad_pkg::F_NONE, mad_pkg::T_ST_Y, 2);
         chk("ram6", 36'(r[1]), 36'(u_mad_mem_model.ram[6]));
         SRC_I = 1'b1;
         RAM_MOD_I = 2'h1;
         run(mad_pkg::F_TSUB, mad_pkg::T_PTR, 1);
         res = a1e - sx(ye);
         chk("acc1_kept", a1e, ACC1_O);
         chk("neg", 36'(res[35]), 36'(NEGATIVE_FLAG_O));
         chk("zero", 36'(res == 36'h0), 36'(ZERO_FLAG_O));
         chk("mv", 36'(!(res[35:31] inside {5'h00, 5'h1f})),
             36'(NARROW_OVERFLOW_FLAG_O));
         DST_I = 1'b0;
         TGT_I = 1'b1;
         run(mad_pkg::F_ADDY, mad_pkg::T_AT, 1);
         chk("acc0", a1e + sx(ye), ACC0_O);
         chk("a1_hi", {{4{r[4][15]}}, r[4], a1e[15:0]}, ACC1_O);
         RAM_MOD_I = 2'h0;
         run(mad_pkg::F_NONE, mad_pkg::T_XCH_YL, 2);
         chk("ram8", 36'(ye[15:0]), 36'(u_mad_mem_model.ram[8]));
         ye[15:0] = r[0];
         chk("y_xch", 36'(ye), 36'(Y_O));
         chk("ram_addr", 36'h8, 36'(RAM_ADDR_O));
      end
      tally_and_finish();
   end
endmodule
